// ---- pkg/psc_pkg.sv ----
// psc_pkg: constants for the privilege status control block.
// assumes a 64-bit machine width hart with machine, supervisor and user modes.
package psc_pkg;
    typedef enum logic [1:0] {
        PSC_PRIV_U = 2'h0,
        PSC_PRIV_S = 2'h1,
        PSC_PRIV_R = 2'h2,
        PSC_PRIV_M = 2'h3
    } psc_priv_t;

    typedef enum logic [1:0] {
        PSC_WAIT_IDLE = 2'h0,
        PSC_WAIT_RUN  = 2'h1
    } psc_wstate_t;

    localparam logic [1:0] PSC_WIDTH_32 = 2'h1;
    localparam logic [1:0] PSC_WIDTH_64 = 2'h2;
    localparam logic [1:0] PSC_WIDTH_NONE = 2'h0;
    localparam int         PSC_XW = 64;
    localparam int         PSC_HW = 32;

    // register offsets, one aligned word each
    localparam logic [7:0] PSC_REG_STATUS = 8'h00;
    localparam logic [7:0] PSC_REG_STATE  = 8'h04;

    // field positions in the status word
    localparam int PSC_B_MODPRIV  = 0;
    localparam int PSC_B_XREAD    = 1;
    localparam int PSC_B_SUM      = 2;
    localparam int PSC_B_MBIG     = 3;
    localparam int PSC_B_SBIG     = 4;
    localparam int PSC_B_UBIG     = 5;
    localparam int PSC_B_TRAPVM   = 6;
    localparam int PSC_B_TWAIT    = 7;
    localparam int PSC_B_TRAPSRET = 8;
    localparam int PSC_B_PP   = 9;
    localparam int PSC_B_UW   = 12;
    localparam int PSC_B_SW   = 14;

    localparam logic [1:0] PSC_PP_RESET = 2'h3;

    // bounded wait-for-interrupt time before a trap
    localparam int PSC_WAIT_NS     = 1000;
    localparam int PSC_CLK_NS      = 5;
    localparam int PSC_WAIT_CYCLES = PSC_WAIT_NS / PSC_CLK_NS;
endpackage

// ---- logic/psc_status_ctrl.sv ----
// psc_status_ctrl: machine status control for width, memory privilege,
// endianness and virtualization traps.
// assumes the pipeline gives one-cycle event pulses and reads results next cycle.
//
// Notes on behaviour
// - on 64-bit harts two fields select supervisor and user register widths.
// - with 32-bit machine width both fields vanish; all widths are 32.
// - supervisor width field reads zero without supervisor mode, else legal-value only.
// - user width field reads zero without user mode, else legal-value only.
// - with supervisor mode, user width may never exceed supervisor width; without it user width may be 64.
// - narrow modes ignore upper source bits and sign-extend results.
// - program counter writes sign-extend from the active width.
// - no cross-mode width ordering check beyond the user field.
// - self-overwriting hints at narrow width sign-fill the upper bits.
// - modify-privilege makes data accesses use previous-privilege mode.
// - modify-privilege reads zero without user mode.
// - trap return to a mode below machine clears modify-privilege.
// - exec-readable lets loads use executable pages under paging.
// - supervisor-user-access gates supervisor access to user pages.
// - these two bits never touch physical attribute or protection faults.
// - fetches always little-endian; machine bit selects machine data order.
// - supervisor and user endianness bits select their modes' order.
// - page table walks use the supervisor endianness bit.
// - trap-virtual-memory traps supervisor translation register and fences.
// - timeout-wait traps lower-mode waits after a bounded time.
// - trap-supervisor-return traps supervisor return in supervisor mode.
`timescale 1ns/100ps
module psc_status_ctrl
    import psc_pkg::*;
#(
    parameter bit HAS_S  = 1'b1,
    parameter bit HAS_U  = 1'b1,
    parameter bit MACH_64 = 1'b1
) (
    input  wire logic        clk,            // hart clock
    input  wire logic        reset_n,        // synchronous reset, low
    input  wire logic [7:0]  reg_addr,       // register byte address
    input  wire logic [31:0] reg_wdata,      // write data
    input  wire logic        reg_wr,         // write strobe
    input  wire logic        reg_rd,         // read strobe
    output logic      [31:0] reg_rdata,      // read data, cycle after strobe
    input  wire logic [1:0]  cur_priv,       // current privilege mode
    input  wire logic        ret_m,          // machine_trap_return pulse
    input  wire logic        ret_s,          // supervisor_trap_return pulse
    input  wire logic [1:0]  ret_target,     // mode the return lands in
    input  wire logic        satp_access,    // translation register access
    input  wire logic        fence_op,       // translation_fence/invalidate
    input  wire logic        wait_start,     // wait_for_interrupt issued
    input  wire logic        wait_done,      // wait completed by interrupt
    input  wire logic        paging_on,      // page translation in effect
    input  wire logic        pte_r,          // page readable
    input  wire logic        pte_x,          // page executable
    input  wire logic        pte_u,          // page user accessible
    input  wire logic        mem_is_load,    // data access is a load
    input  wire logic        mem_is_fetch,   // access is a fetch
    input  wire logic        mem_is_walk,    // implicit page table access
    input  wire logic        attr_fault,     // physical_attributes fault
    input  wire logic        prot_fault,     // physical_protection fault
    input  wire logic [63:0] res_in,         // raw result or pc value
    output logic             illegal_instr,  // illegal-instruction trap
    output logic [1:0]       eff_priv,       // data access privilege
    output logic             eff_big_endian, // access byte order
    output logic             page_fault,     // page permission fault
    output logic             access_fault,   // attribute/protection fault
    output logic [63:0]      res_out         // width-adjusted value
);
    logic        modify_privilege;
    logic        exec_readable;
    logic        sup_user_access;
    logic        machine_big_endian;
    logic        supervisor_big_endian;
    logic        user_big_endian;
    logic        trap_virtual_memory;
    logic        timeout_wait;
    logic        trap_supervisor_return;
    logic [1:0]  previous_privilege;
    logic [1:0]  supervisor_width_sel;
    logic [1:0]  user_width_sel;
    logic [15:0] wait_cnt;
    psc_wstate_t wstate;

    function automatic logic [63:0] sext(input logic [63:0] v, input logic [1:0] w);
        sext = (w == PSC_WIDTH_32) ? {{PSC_HW{v[PSC_HW-1]}}, v[PSC_HW-1:0]} : v;
    endfunction

    function automatic logic [1:0] legal_pp(input logic [1:0] p);
        legal_pp = (p == PSC_PRIV_S && HAS_S) ? p :
                   (p == PSC_PRIV_U && HAS_U) ? p : PSC_PRIV_M;
    endfunction

    wire wr_st = reg_wr && reg_addr == PSC_REG_STATUS;
    wire [1:0] sxw = reg_wdata[PSC_B_SW+1:PSC_B_SW];
    wire [1:0] uxw = reg_wdata[PSC_B_UW+1:PSC_B_UW];
    wire [1:0] next_sw = (sxw == PSC_WIDTH_32 || sxw == PSC_WIDTH_64) ? sxw
                                                                     : supervisor_width_sel;
    // user width never wider than supervisor when supervisor mode exists, else capped at 64
    wire [1:0] ucap = HAS_S ? next_sw : PSC_WIDTH_64;
    wire [1:0] next_uw = ((uxw == PSC_WIDTH_32 || uxw == PSC_WIDTH_64) && uxw <= ucap)
                         ? uxw : ((user_width_sel <= ucap) ? user_width_sel : ucap);
    wire ret_low = (ret_m || ret_s) && ret_target != PSC_PRIV_M;

    // width selection
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            supervisor_width_sel <= (MACH_64 && HAS_S) ? PSC_WIDTH_64 : PSC_WIDTH_NONE;
            user_width_sel       <= (MACH_64 && HAS_U) ? PSC_WIDTH_64 : PSC_WIDTH_NONE;
        end else if (wr_st && MACH_64) begin
            if (HAS_S) supervisor_width_sel <= next_sw;
            if (HAS_U) user_width_sel <= next_uw;
        end
    end

    // memory privilege, endianness, virtualization bits
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            modify_privilege       <= 1'b0;
            exec_readable          <= 1'b0;
            sup_user_access        <= 1'b0;
            machine_big_endian     <= 1'b0;
            supervisor_big_endian  <= 1'b0;
            user_big_endian        <= 1'b0;
            trap_virtual_memory    <= 1'b0;
            timeout_wait           <= 1'b0;
            trap_supervisor_return <= 1'b0;
            previous_privilege     <= PSC_PP_RESET;
        end else begin
            if (wr_st) begin
                modify_privilege       <= HAS_U && reg_wdata[PSC_B_MODPRIV];
                exec_readable          <= HAS_S && reg_wdata[PSC_B_XREAD];
                sup_user_access        <= HAS_S && reg_wdata[PSC_B_SUM];
                machine_big_endian     <= reg_wdata[PSC_B_MBIG];
                supervisor_big_endian  <= HAS_S && reg_wdata[PSC_B_SBIG];
                user_big_endian        <= HAS_U && reg_wdata[PSC_B_UBIG];
                trap_virtual_memory    <= HAS_S && reg_wdata[PSC_B_TRAPVM];
                timeout_wait           <= HAS_U && reg_wdata[PSC_B_TWAIT];
                trap_supervisor_return <= HAS_S && reg_wdata[PSC_B_TRAPSRET];
                previous_privilege     <= legal_pp(reg_wdata[PSC_B_PP+1:PSC_B_PP]);
            end
            // return below machine wins over a same-cycle write
            if (ret_low) modify_privilege <= 1'b0;
        end
    end

    // bounded wait timer for lower-mode waits
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wstate   <= PSC_WAIT_IDLE;
            wait_cnt <= '0;
        end else begin
            unique case (wstate)
                PSC_WAIT_IDLE: begin
                    wait_cnt <= '0;
                    if (wait_start && cur_priv != PSC_PRIV_M && !wait_done)
                        wstate <= PSC_WAIT_RUN;
                end
                PSC_WAIT_RUN: begin
                    wait_cnt <= wait_cnt + 16'h0001;
                    if (wait_done || wait_cnt == 16'(PSC_WAIT_CYCLES - 1))
                        wstate <= PSC_WAIT_IDLE;
                end
                default: wstate <= PSC_WAIT_IDLE;
            endcase
        end
    end

    wire wait_trap_en = (timeout_wait || (HAS_S && cur_priv == PSC_PRIV_U))
                        && wstate == PSC_WAIT_RUN && !wait_done
                        && wait_cnt == 16'(PSC_WAIT_CYCLES - 1);

    // illegal-instruction traps, one cycle after cause
    always_ff @(posedge clk) begin
        if (!reset_n) illegal_instr <= 1'b0;
        else illegal_instr <=
            (trap_virtual_memory && cur_priv == PSC_PRIV_S && (satp_access || fence_op))
            || (trap_supervisor_return && cur_priv == PSC_PRIV_S && ret_s)
            || wait_trap_en;
    end

    // effective privilege and byte order for data
    wire [1:0] ep = (modify_privilege && !mem_is_fetch) ? previous_privilege : cur_priv;
    wire be_mode = (ep == PSC_PRIV_M) ? machine_big_endian :
                   (ep == PSC_PRIV_S) ? supervisor_big_endian : user_big_endian;
    wire [1:0] ew = (ep == PSC_PRIV_M || !MACH_64) ? PSC_WIDTH_64 - {1'b0, !MACH_64} :
                    (ep == PSC_PRIV_S) ? supervisor_width_sel : user_width_sel;
    wire rd_ok = pte_r || (exec_readable && pte_x);
    wire perm_bad = paging_on && !mem_is_fetch &&
                    ((mem_is_load && !rd_ok) ||
                     (ep == PSC_PRIV_S && pte_u && !sup_user_access));

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            eff_priv       <= PSC_PRIV_M;
            eff_big_endian <= 1'b0;
            page_fault     <= 1'b0;
            access_fault   <= 1'b0;
            res_out        <= '0;
        end else begin
            eff_priv       <= ep;
            eff_big_endian <= mem_is_fetch ? 1'b0 :
                              mem_is_walk ? supervisor_big_endian : be_mode;
            page_fault     <= perm_bad;
            access_fault   <= attr_fault || prot_fault;
            res_out        <= sext(res_in, ew);
        end
    end

    // register reads; the state word shows the wait timer
    always_ff @(posedge clk) begin
        if (!reset_n) reg_rdata <= '0;
        else if (reg_rd) begin
            unique case (reg_addr)
                PSC_REG_STATUS: begin
                    reg_rdata <= '0;
                    reg_rdata[PSC_B_MODPRIV]  <= modify_privilege;
                    reg_rdata[PSC_B_XREAD]    <= exec_readable;
                    reg_rdata[PSC_B_SUM]      <= sup_user_access;
                    reg_rdata[PSC_B_MBIG]     <= machine_big_endian;
                    reg_rdata[PSC_B_SBIG]     <= supervisor_big_endian;
                    reg_rdata[PSC_B_UBIG]     <= user_big_endian;
                    reg_rdata[PSC_B_TRAPVM]   <= trap_virtual_memory;
                    reg_rdata[PSC_B_TWAIT]    <= timeout_wait;
                    reg_rdata[PSC_B_TRAPSRET] <= trap_supervisor_return;
                    reg_rdata[PSC_B_PP+1:PSC_B_PP] <= previous_privilege;
                    reg_rdata[PSC_B_UW+1:PSC_B_UW] <= user_width_sel;
                    reg_rdata[PSC_B_SW+1:PSC_B_SW] <= supervisor_width_sel;
                end
                PSC_REG_STATE: reg_rdata <= {14'h0000, wait_cnt, wstate};
                default: reg_rdata <= '0;
            endcase
        end else reg_rdata <= '0;
    end

    a_ret_clears: assert property (@(posedge clk) disable iff (!reset_n)
        ret_low |=> !modify_privilege) else $error("return kept modify bit");
    a_tvm_trap: assert property (@(posedge clk) disable iff (!reset_n)
        trap_virtual_memory && cur_priv == PSC_PRIV_S && satp_access |=> illegal_instr)
        else $error("translation access not trapped");
    a_tsr_trap: assert property (@(posedge clk) disable iff (!reset_n)
        trap_supervisor_return && cur_priv == PSC_PRIV_S && ret_s |=> illegal_instr)
        else $error("supervisor return not trapped");
    a_fetch_le: assert property (@(posedge clk) disable iff (!reset_n)
        mem_is_fetch |=> !eff_big_endian) else $error("fetch not little endian");
    a_walk_sbe: assert property (@(posedge clk) disable iff (!reset_n)
        mem_is_walk && !mem_is_fetch |=> eff_big_endian == $past(supervisor_big_endian))
        else $error("walk order wrong");
    a_user_cap: assert property (@(posedge clk) disable iff (!reset_n)
        HAS_S |-> user_width_sel <= supervisor_width_sel)
        else $error("user width above supervisor");
    a_modify_privilege_priv: assert property (@(posedge clk) disable iff (!reset_n)
        modify_privilege && !mem_is_fetch |=> eff_priv == $past(previous_privilege))
        else $error("effective privilege wrong");
    a_fault_pass: assert property (@(posedge clk) disable iff (!reset_n)
        (attr_fault || prot_fault) |=> access_fault) else $error("access fault lost");

    // named steps of the trap paths
    sequence s_tvm_cause;
        trap_virtual_memory && cur_priv == PSC_PRIV_S && (satp_access || fence_op);
    endsequence

    sequence s_wait_expire;
        wstate == PSC_WAIT_RUN && !wait_done && wait_cnt == 16'(PSC_WAIT_CYCLES - 1);
    endsequence

    a_fence_trap: assert property (@(posedge clk) disable iff (!reset_n)
        s_tvm_cause |=> illegal_instr) else $error("fence not trapped");
    a_wait_trap: assert property (@(posedge clk) disable iff (!reset_n)
        s_wait_expire ##0 (timeout_wait || (HAS_S && cur_priv == PSC_PRIV_U))
        |=> illegal_instr) else $error("expired wait not trapped");
    a_wait_bound: assert property (@(posedge clk) disable iff (!reset_n)
        wstate == PSC_WAIT_RUN |-> wait_cnt < 16'(PSC_WAIT_CYCLES))
        else $error("wait counter past bound");
    a_m_quiet: assert property (@(posedge clk) disable iff (!reset_n)
        cur_priv == PSC_PRIV_M && wstate != PSC_WAIT_RUN |=> !illegal_instr)
        else $error("trap raised in machine mode");
    a_modify_privilege_absent: assert property (@(posedge clk) disable iff (!reset_n)
        !HAS_U |-> !modify_privilege) else $error("modify bit without user mode");
    a_s_absent: assert property (@(posedge clk) disable iff (!reset_n)
        !HAS_S |-> !exec_readable && !trap_virtual_memory && !trap_supervisor_return)
        else $error("supervisor bit without supervisor mode");
    a_width_fixed: assert property (@(posedge clk) disable iff (!reset_n)
        !MACH_64 |-> supervisor_width_sel == PSC_WIDTH_NONE && user_width_sel == PSC_WIDTH_NONE)
        else $error("width field present at 32 bits");
endmodule

// ---- sim/tb_privilege_status_control.sv ----
// tb_privilege_status_control: self-checking bench for psc_status_ctrl.
// assumes the default parameters: 64-bit machine width, supervisor and user modes.
`timescale 1ns/100ps
`define chk(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_privilege_status_control
    import psc_pkg::*;
;
    logic        clk, reset_n, reg_wr, reg_rd, ret_m, ret_s, satp_access, fence_op;
    logic        wait_start, wait_done, paging_on, pte_r, pte_x, pte_u, mem_is_load;
    logic        mem_is_fetch, mem_is_walk, attr_fault, prot_fault, illegal_instr;
    logic        eff_big_endian, page_fault, access_fault;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic [1:0]  cur_priv, ret_target, eff_priv;
    logic [63:0] res_in, res_out;
    logic [4:0]  etab [5] = '{5'b11001, 5'b11100, 5'b00001, 5'b01000, 5'b00010};
    logic [7:0]  ptab [5] = '{8'h12, 8'h90, 8'h2a, 8'h68, 8'hed};
    int          fails, checked, n;

    psc_status_ctrl i_psc_status_ctrl (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cur_priv, .ret_m, .ret_s, .ret_target, .satp_access,
        .fence_op, .wait_start, .wait_done, .paging_on, .pte_r, .pte_x, .pte_u,
        .mem_is_load, .mem_is_fetch, .mem_is_walk, .attr_fault, .prot_fault, .res_in,
        .illegal_instr, .eff_priv, .eff_big_endian, .page_fault, .access_fault, .res_out);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk); reg_wr <= 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk); reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk); reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task ev(input int k, input logic ex);
        @(posedge clk);
        case (k)
            0: satp_access <= 1'b1;
            1: fence_op <= 1'b1;
            2: ret_s <= 1'b1;
            default: ret_m <= 1'b1;
        endcase
        @(posedge clk); {satp_access, fence_op, ret_s, ret_m} <= 4'h0;
        #1 `chk("illegal_instr", ex, illegal_instr)
    endtask

    // cycles until illegal_instr after a wait starts, -1 if none
    task watch(input int lim, input logic done, output int first);
        @(posedge clk); wait_start <= 1'b1;
        @(posedge clk); wait_start <= 1'b0;
        first = -1;
        for (int i = 1; i <= lim; i++) begin
            @(posedge clk);
            wait_done <= done && (i == 10);
            #1 if (illegal_instr === 1'b1 && first < 0) first = i;
        end
    endtask

    task t_reset;
        rd(PSC_REG_STATUS, rv); `chk("status", 32'h0000a600, rv)
        rd(PSC_REG_STATE, rv);  `chk("state", 32'h00000000, rv)
        rd(8'h40, rv);          `chk("unmapped", 32'h00000000, rv)
        `chk("eff_priv", 2'h3, eff_priv)
    endtask

    task t_width;
        wr(PSC_REG_STATUS, 32'h00006600);
        rd(PSC_REG_STATUS, rv); `chk("user clamp", 32'h00005600, rv)
        wr(PSC_REG_STATUS, 32'h0000f600);
        rd(PSC_REG_STATUS, rv); `chk("bad width", 32'h00005600, rv)
        @(posedge clk); cur_priv <= PSC_PRIV_S; res_in <= 64'h12345678_80000001;
        settle; `chk("res_out", 64'hffffffff_80000001, res_out)
        @(posedge clk); res_in <= 64'hffff0000_7ffffffe;
        settle; `chk("res_out", 64'h00000000_7ffffffe, res_out)
        @(posedge clk); cur_priv <= PSC_PRIV_M;
        settle; `chk("res_out", 64'hffff0000_7ffffffe, res_out)
        wr(PSC_REG_STATUS, 32'h0000a600);
    endtask

    task t_modify_privilege;
        wr(PSC_REG_STATUS, 32'h0000a201);
        settle; `chk("eff_priv", 2'h1, eff_priv)
        ret_target <= PSC_PRIV_U;
        ev(3, 1'b0);
        rd(PSC_REG_STATUS, rv); `chk("modify bit", 1'b0, rv[PSC_B_MODPRIV])
        settle; `chk("eff_priv", 2'h3, eff_priv)
    endtask

    task t_endian;
        wr(PSC_REG_STATUS, 32'h0000a628);
        ev(1, 1'b0);
        foreach (etab[i]) begin
            @(posedge clk); {cur_priv, mem_is_fetch, mem_is_walk} <= etab[i][4:1];
            settle; `chk("eff_big_endian", etab[i][0], eff_big_endian)
        end
    endtask

    task t_perm;
        @(posedge clk); paging_on <= 1'b1; cur_priv <= PSC_PRIV_S; mem_is_fetch <= 1'b0;
        foreach (ptab[i]) begin
            wr(PSC_REG_STATUS, 32'h0000a600 | {29'h0, ptab[i][6], ptab[i][7], 1'b0});
            @(posedge clk); {pte_r, pte_x, pte_u, attr_fault} <= ptab[i][5:2];
            settle; `chk("page_fault", ptab[i][1], page_fault)
            `chk("access_fault", ptab[i][0], access_fault)
        end
        @(posedge clk); attr_fault <= 1'b0; prot_fault <= 1'b1;
        settle; `chk("access_fault", 1'b1, access_fault)
        @(posedge clk); prot_fault <= 1'b0;
    endtask

    task t_traps;
        wr(PSC_REG_STATUS, 32'h0000a740);
        ev(0, 1'b1);
        ev(1, 1'b1);
        ev(2, 1'b1);
        @(posedge clk); cur_priv <= PSC_PRIV_M;
        ev(0, 1'b0);
        ev(2, 1'b0);
        wr(PSC_REG_STATUS, 32'h0000a600);
        @(posedge clk); cur_priv <= PSC_PRIV_S;
        ev(0, 1'b0);
        ev(2, 1'b0);
    endtask

    task t_wait;
        wr(PSC_REG_STATUS, 32'h0000a680);
        watch(PSC_WAIT_CYCLES + 20, 1'b0, n);
        `chk("wait bound", 1'b1, n >= PSC_WAIT_CYCLES - 2 && n <= PSC_WAIT_CYCLES + 2)
        watch(PSC_WAIT_CYCLES + 50, 1'b1, n); `chk("wait done", -1, n)
        wr(PSC_REG_STATUS, 32'h0000a600);
        watch(PSC_WAIT_CYCLES + 50, 1'b0, n); `chk("wait s", -1, n)
        @(posedge clk); cur_priv <= PSC_PRIV_U;
        watch(PSC_WAIT_CYCLES + 20, 1'b0, n); `chk("wait u", 1'b1, n > 0)
    endtask

    task wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        {reset_n, reg_wr, reg_rd, ret_m, ret_s, satp_access, fence_op, wait_start} = 8'h00;
        {wait_done, paging_on, pte_r, pte_x, pte_u, mem_is_fetch, mem_is_walk} = 7'h00;
        {attr_fault, prot_fault} = 2'h0;
        mem_is_load = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        cur_priv = PSC_PRIV_M;
        ret_target = PSC_PRIV_U;
        res_in = 64'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        t_reset;
        t_width;
        t_modify_privilege;
        t_endian;
        t_perm;
        t_traps;
        t_wait;
        wrap_up;
    end

    initial begin
        #60000;
        fails++;
        wrap_up;
    end
endmodule
